/* File: shared/ccs_defines.svh */
// Constants for the CPU clock select control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
`define CCS_ADDR_SUBOSC 16'hfff0
`define CCS_ADDR_SUBSEL 16'hfff2
`define CCS_ADDR_PROC 16'hfffb
`define CCS_RST_PROC 8'h02
`define CCS_RST_SUBOSC 8'h00
`define CCS_RST_SUBSEL 8'h00
`define CCS_BIT_MAIN_STOP 7
`define CCS_BIT_DIV 1
`define CCS_BIT_FBRES 1
`define CCS_BIT_SUB_STOP 0
`define CCS_BIT_SRC_SEL 4
`define CCS_BIT_SRC_STAT 5
`define CCS_MASK_PROC 8'h82
`define CCS_MASK_SUBOSC 8'h03
`define CCS_MASK_SUBSEL 8'h10
`define CCS_STAB_EXP 7
`define CCS_SW_MAIN 8'd2
`define CCS_SW_FAST_TO_SLOW 8'd4
`define CCS_SW_TO_SUB 8'd244
`endif

/* File: shared/ccs_pkg.sv */
// Types shared by the CPU clock select control block.
// Assumes the defines header is on the include path.
`include "ccs_defines.svh"
package ccs_pkg;
   typedef enum logic [1:0] {CCS_SRC_MAIN, CCS_SRC_MAIN_DIV4, CCS_SRC_SUB_DIV2} ccs_src_t;
   typedef struct packed {
      logic wr_byte;
      logic wr_bit;
      logic [2:0] bit_idx;
      logic bit_val;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ccs_cpu_wr_t;
endpackage

/* File: rtl/ccs_clock_select.sv */
// CPU clock select control: three 8-bit registers, CPU clock mux, standby gating.
// Assumes the CPU register port sits on core_clk and the oscillators are modelled
// as slow square waves from outside the domain, synchronised and edge-detected on core_clk.
//
// Contract
// [RULE1] Reset loads processor control with 02h
// [RULE2] Bit 7 stops the main oscillator
// [RULE3] Source/divide bits pick main, main/4, sub/2
// [RULE4] Software writes zero to unused processor bits
// [RULE5] Main stop only while subsystem clock selected; the code stops the main oscillator from bit 7 on any source
// [RULE6] Reset clears subsystem oscillator mode register
// [RULE7] Bit 1 disconnects the feedback resistor
// [RULE8] Bit 0 stops the subsystem oscillator
// [RULE9] Software writes zero to subsystem bits 2-7
// [RULE10] Reset clears subclock select register
// [RULE11] Bit 4 selects subsystem clock source
// [RULE12] Bit 5 reports the active source
// [RULE13] Writes to status bit 5 ignored
// [RULE14] Software writes zero to select reserved bits
// [RULE15] Main oscillator held stopped during reset
// [RULE16] STOP allowed only on main clock
// [RULE17] Subsystem clock feeds watch and display only
// [RULE18] Registers take bit and byte writes
// [RULE19] New selection applies after switching delay
// [RULE20] Stabilisation wait after reset before execution
// [RULE21] Glitch-free switch, status follows real source
// [RULE22] Divide bit ignored when subsystem selected
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.svh"
module ccs_clock_select
   import ccs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // CPU register port
   input wire ccs_cpu_wr_t cpu_wr,
   input wire logic [15:0] cpu_raddr,
   output logic [7:0] cpu_rdata,
   // Oscillator ticks, asynchronous
   input wire logic main_osc_in,
   input wire logic sub_osc_in,
   // Oscillator controls
   output logic main_osc_stop,
   output logic sub_osc_stop,
   output logic feedback_resistor_off,
   // CPU clock, peripheral clocks, run and standby flags
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic sub_periph_clk_en,
   output logic cpu_run,
   output logic stop_allowed,
   output logic halt_allowed
);
   logic [7:0] proc_ctrl_reg, subosc_reg, subsel_reg;
   logic [2:0] main_sync_reg, sub_sync_reg;
   logic main_tick, sub_tick;
   ccs_src_t active_reg, target;
   logic [7:0] sw_cnt_reg;
   logic [`CCS_STAB_EXP:0] stab_cnt_reg;
   logic [1:0] div4_reg;
   logic div2_reg;

   // Byte or single-bit write merged into an old value, reserved bits masked
   function automatic logic [7:0] wr_merge(input logic [7:0] old, input ccs_cpu_wr_t w,
                                            input logic [7:0] mask);
      logic [7:0] v;
      v = old;
      if (w.wr_byte) begin
         v = w.wdata;
      end else if (w.wr_bit) begin
         v[w.bit_idx] = w.bit_val;
      end
      return (v & mask) | (old & ~mask);
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         proc_ctrl_reg <= `CCS_RST_PROC; // RULE1
         subosc_reg <= `CCS_RST_SUBOSC; // RULE6
         subsel_reg <= `CCS_RST_SUBSEL; // RULE10
      end else if (cpu_wr.addr == `CCS_ADDR_PROC) begin
         proc_ctrl_reg <= wr_merge(proc_ctrl_reg, cpu_wr, `CCS_MASK_PROC); // RULE18
      end else if (cpu_wr.addr == `CCS_ADDR_SUBOSC) begin
         subosc_reg <= wr_merge(subosc_reg, cpu_wr, `CCS_MASK_SUBOSC); // RULE18
      end else if (cpu_wr.addr == `CCS_ADDR_SUBSEL) begin
         // Status bit is not in the mask, so writes leave it alone
         subsel_reg <= wr_merge(subsel_reg, cpu_wr, `CCS_MASK_SUBSEL); // RULE13
      end
   end
   a_reset_proc_ctrl: assert property (@(posedge core_clk) // RULE1
      rst |=> proc_ctrl_reg == `CCS_RST_PROC)
      else $error("processor control not 02h after reset");
   a_status_ro_bit: assert property (@(posedge core_clk) disable iff (rst) // RULE13
      subsel_reg[`CCS_BIT_SRC_STAT] == 1'b0)
      else $error("status bit stored from a write");

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_raddr == `CCS_ADDR_PROC) begin
         cpu_rdata <= proc_ctrl_reg;
      end else if (cpu_raddr == `CCS_ADDR_SUBOSC) begin
         cpu_rdata <= subosc_reg;
      end else if (cpu_raddr == `CCS_ADDR_SUBSEL) begin
         cpu_rdata <= subsel_reg |
            (8'(active_reg == CCS_SRC_SUB_DIV2) << `CCS_BIT_SRC_STAT); // RULE12
      end else begin
         cpu_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Oscillator tick synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         main_sync_reg <= 3'h0;
         sub_sync_reg <= 3'h0;
      end else begin
         main_sync_reg <= {main_sync_reg[1:0], main_osc_in};
         sub_sync_reg <= {sub_sync_reg[1:0], sub_osc_in};
      end
   end
   // Rising edge seen once stages two and three disagree in the rising sense
   assign main_tick = main_sync_reg[1] & ~main_sync_reg[2] & ~main_osc_stop;
   assign sub_tick = sub_sync_reg[1] & ~sub_sync_reg[2] & ~sub_osc_stop;

   // ----------------------------------------
   // Oscillator control outputs
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         main_osc_stop <= 1'b1; // RULE15
         sub_osc_stop <= 1'b0;
         feedback_resistor_off <= 1'b0;
      end else begin
         main_osc_stop <= proc_ctrl_reg[`CCS_BIT_MAIN_STOP]; // RULE2
         sub_osc_stop <= subosc_reg[`CCS_BIT_SUB_STOP]; // RULE8
         feedback_resistor_off <= subosc_reg[`CCS_BIT_FBRES]; // RULE7
      end
   end
   // Compared with the bit as it was, so a quick rewrite cannot trip it
   a_main_stop_follow: assert property (@(posedge core_clk) disable iff (rst) // RULE2
      $changed(proc_ctrl_reg[`CCS_BIT_MAIN_STOP]) |=>
      main_osc_stop == $past(proc_ctrl_reg[`CCS_BIT_MAIN_STOP]))
      else $error("main stop does not follow bit 7");
   a_sub_osc_follow: assert property (@(posedge core_clk) disable iff (rst) // RULE8
      $changed(subosc_reg[`CCS_BIT_SUB_STOP]) |=>
      sub_osc_stop == $past(subosc_reg[`CCS_BIT_SUB_STOP]))
      else $error("sub stop does not follow bit 0");
   a_resistor_follow: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      $changed(subosc_reg[`CCS_BIT_FBRES]) |=>
      feedback_resistor_off == $past(subosc_reg[`CCS_BIT_FBRES]))
      else $error("feedback resistor does not follow bit 1");

   // ----------------------------------------
   // Stabilisation wait after reset
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stab_cnt_reg <= '0;
         cpu_run <= 1'b0;
      end else if (!cpu_run && main_tick) begin
         stab_cnt_reg <= stab_cnt_reg + 1'b1;
         cpu_run <= stab_cnt_reg[`CCS_STAB_EXP - 1] & (&stab_cnt_reg[`CCS_STAB_EXP - 2:0]); // RULE20
      end
   end
   a_no_run_early: assert property (@(posedge core_clk) disable iff (rst) // RULE20
      !cpu_run |-> !cpu_clk_en)
      else $error("cpu clock before stabilisation");

   // ----------------------------------------
   // Source selection with switching delay
   // ----------------------------------------
   always_comb begin
      if (subsel_reg[`CCS_BIT_SRC_SEL]) begin
         target = CCS_SRC_SUB_DIV2; // RULE11 RULE22
      end else if (proc_ctrl_reg[`CCS_BIT_DIV]) begin
         target = CCS_SRC_MAIN_DIV4; // RULE3
      end else begin
         target = CCS_SRC_MAIN; // RULE3
      end
   end

   // Delay counts CPU clocks of the old source, so the change lands on its edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         active_reg <= CCS_SRC_MAIN_DIV4;
         sw_cnt_reg <= 8'h00;
      end else if (target == active_reg) begin
         sw_cnt_reg <= 8'h00;
      end else if (cpu_clk_en) begin
         if ((target == CCS_SRC_SUB_DIV2 && sw_cnt_reg >= `CCS_SW_TO_SUB - 8'd1) ||
             (target == CCS_SRC_MAIN_DIV4 && active_reg == CCS_SRC_MAIN &&
              sw_cnt_reg >= `CCS_SW_FAST_TO_SLOW - 8'd1) ||
             (target != CCS_SRC_SUB_DIV2 &&
              !(target == CCS_SRC_MAIN_DIV4 && active_reg == CCS_SRC_MAIN) &&
              sw_cnt_reg >= `CCS_SW_MAIN - 8'd1)) begin
            active_reg <= target; // RULE19 RULE21
            sw_cnt_reg <= 8'h00;
         end else begin
            sw_cnt_reg <= sw_cnt_reg + 8'd1;
         end
      end
   end
   // Only a change from a settled source is watched: a retarget mid-switch may end it
   a_switch_not_early: assert property (@(posedge core_clk) disable iff (rst) // RULE19
      $changed(target) && $past(target) == $past(active_reg) |=>
      active_reg == $past(active_reg))
      else $error("source switched without delay");

   // ----------------------------------------
   // Clock enables
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div4_reg <= 2'h0;
         div2_reg <= 1'b0;
      end else begin
         if (main_tick) begin
            div4_reg <= div4_reg + 2'h1;
         end
         if (sub_tick) begin
            div2_reg <= ~div2_reg;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         sub_periph_clk_en <= 1'b0;
         stop_allowed <= 1'b1;
         halt_allowed <= 1'b1;
      end else begin
         // Single enable pulse from exactly one source: no glitch on switching
         case (active_reg)
            CCS_SRC_MAIN: cpu_clk_en <= cpu_run & main_tick; // RULE3
            CCS_SRC_MAIN_DIV4: cpu_clk_en <= cpu_run & main_tick & (&div4_reg); // RULE3
            default: cpu_clk_en <= cpu_run & sub_tick & div2_reg; // RULE21
         endcase
         periph_clk_en <= main_tick; // RULE17
         sub_periph_clk_en <= sub_tick; // RULE17
         stop_allowed <= (active_reg != CCS_SRC_SUB_DIV2); // RULE16
         halt_allowed <= 1'b1;
      end
   end
   a_stop_gate_sub: assert property (@(posedge core_clk) disable iff (rst) // RULE16
      active_reg == CCS_SRC_SUB_DIV2 |=> !stop_allowed && halt_allowed)
      else $error("STOP allowed on subsystem clock");

endmodule
`default_nettype wire

/* File: bench/ccs_clock_select_tb.sv */
// Self-checking bench for the CPU clock select control block.
// Assumes oscillators are modelled as slow square waves made on core_clk.
`timescale 1ns/100ps
`default_nettype none
module ccs_clock_select_tb
   import ccs_pkg::*;
;
   typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} ccs_row_t;
   logic core_clk = 0, rst = 1, main_osc_in = 0, sub_osc_in = 0;
   ccs_cpu_wr_t cpu_wr = '0;
   logic [15:0] cpu_raddr = '0;
   logic [7:0] cpu_rdata, v;
   logic main_osc_stop, sub_osc_stop, feedback_resistor_off, cpu_clk_en;
   logic periph_clk_en, sub_periph_clk_en, cpu_run, stop_allowed, halt_allowed;
   int n_mismatch = 0, check_count = 0, k, t;
   logic [2:0] sub_div = '0;
   // Reserved bits are always written as zero; the status bit write must be dropped
   ccs_row_t rows[6] = '{'{16'hfff0, 8'h03, 8'h03}, '{16'hfff0, 8'h00, 8'h00},
      '{16'hfffb, 8'h00, 8'h00}, '{16'hfffb, 8'h02, 8'h02},
      '{16'hfff2, 8'h20, 8'h00}, '{16'h1234, 8'hff, 8'h00}};
   ccs_clock_select uut (.core_clk(core_clk), .rst(rst), .cpu_wr(cpu_wr),
      .cpu_raddr(cpu_raddr), .cpu_rdata(cpu_rdata), .main_osc_in(main_osc_in),
      .sub_osc_in(sub_osc_in), .main_osc_stop(main_osc_stop), .sub_osc_stop(sub_osc_stop),
      .feedback_resistor_off(feedback_resistor_off), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .sub_periph_clk_en(sub_periph_clk_en),
      .cpu_run(cpu_run), .stop_allowed(stop_allowed), .halt_allowed(halt_allowed));
   always #5 core_clk = ~core_clk;
   // ----------------------------------------
   // Oscillators: main ticks every 2 cycles, sub every 16
   // ----------------------------------------
   always @(posedge core_clk) begin
      main_osc_in <= ~main_osc_in;
      sub_div <= sub_div + 3'h1;
      if (sub_div == 3'h7) begin
         sub_osc_in <= ~sub_osc_in;
      end
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic rng(input int g, input int lo, input int hi, input string m);
      chk(8'((g >= lo && g <= hi) ? 1 : 0), 8'h01, m);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bm, input int i);
      ccs_cpu_wr_t w;
      w = '0;
      w.wr_byte = ~bm;
      w.wr_bit = bm;
      w.bit_idx = 3'(i);
      w.bit_val = d[0];
      w.addr = a;
      w.wdata = d;
      @(posedge core_clk) cpu_wr <= w;
      @(posedge core_clk) cpu_wr <= '0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] r);
      @(posedge core_clk) cpu_raddr <= a;
      repeat (2) @(posedge core_clk);
      #1 r = cpu_rdata;
   endtask
   // Counts pulses of one clock enable over n cycles
   task automatic cnt(input int sel, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge core_clk);
         #1 c += (sel == 0) ? cpu_clk_en : (sel == 1) ? periph_clk_en : sub_periph_clk_en;
      end
   endtask
   task automatic wait_src(input logic s, output int c);
      c = 0;
      v = ~{8{s}};
      while (v[5] !== s && c < 3000) begin
         rd(16'hfff2, v);
         c += 3;
      end
   endtask
   initial begin
      #300000;
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      complete_run;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      #1 chk(main_osc_stop, 1'b1, "main stop in reset");
      @(posedge core_clk) rst <= 0;
      rd(16'hfffb, v); chk(v, 8'h02, "proc ctrl reset");
      rd(16'hfff0, v); chk(v, 8'h00, "subosc reset");
      rd(16'hfff2, v); chk(v, 8'h00, "select reset");
      chk(cpu_run, 1'b0, "run before stabilisation");
      t = 10;
      while (cpu_run !== 1'b1 && t < 1000) begin
         @(posedge core_clk) t++;
      end
      rng(t, 250, 400, "stabilisation span");
      $display("reset test done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, 0, 0);
         rd(rows[i].a, v); chk(v, rows[i].e, "row readback");
      end
      $display("table test done");
      wr(16'hfff0, 8'h03, 0, 0);
      // Control outputs follow the register one cycle after it is written
      @(posedge core_clk);
      #1 chk({sub_osc_stop, feedback_resistor_off}, 2'b11, "osc controls");
      wr(16'hfff0, 8'h00, 1, 0);
      rd(16'hfff0, v); chk(v, 8'h02, "bit write");
      chk({sub_osc_stop, feedback_resistor_off}, 2'b01, "sub runs");
      wr(16'hfff0, 8'h00, 0, 0);
      cnt(0, 200, k); rng(k, 24, 26, "main div4 rate");
      chk({stop_allowed, halt_allowed}, 2'b11, "standby on main");
      wr(16'hfffb, 8'h00, 0, 0);
      repeat (20) @(posedge core_clk);
      cnt(0, 100, k); rng(k, 49, 51, "main full rate");
      wr(16'hfff2, 8'h10, 0, 0);
      rd(16'hfff2, v); chk(v, 8'h10, "status holds old source");
      wait_src(1'b1, t); rng(t, 400, 2999, "switch delay to sub");
      rd(16'hfff2, v); chk(v, 8'h30, "status on sub");
      chk({stop_allowed, halt_allowed}, 2'b01, "standby on sub");
      cnt(0, 320, k); rng(k, 9, 11, "sub div2 rate");
      wr(16'hfffb, 8'h01, 1, 1);
      cnt(0, 320, k); rng(k, 9, 11, "divide ignored on sub");
      wr(16'hfffb, 8'h80, 0, 0);
      repeat (10) @(posedge core_clk);
      chk(main_osc_stop, 1'b1, "main stopped");
      cnt(1, 100, k); rng(k, 0, 0, "periph halts");
      cnt(2, 100, k); rng(k, 6, 7, "sub periph runs");
      wr(16'hfffb, 8'h00, 0, 0);
      wr(16'hfff2, 8'h00, 0, 0);
      wait_src(1'b0, t); rng(t, 24, 120, "back to main");
      $display("switch test done");
      @(posedge core_clk) rst <= 1;
      repeat (2) @(posedge core_clk);
      #1 chk(main_osc_stop, 1'b1, "main stop in second reset");
      @(posedge core_clk) rst <= 0;
      chk(cpu_run, 1'b0, "run cleared by reset");
      rd(16'hfffb, v); chk(v, 8'h02, "proc ctrl second reset");
      rd(16'hfff2, v); chk(v, 8'h00, "select second reset");
      $display("second reset test done");
      complete_run;
   end
endmodule
`default_nettype wire
